// ===== common/ddr_init_pkg.sv
// shared constants, types and helpers for the DDR4 power-up link
package ddr_init_pkg;
    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // clock and timing
    localparam int CLK_MHZ        = 10;
    localparam int CLK_NS         = 100;
    localparam int T_RST_PWR_US   = 200;
    localparam int RST_PWR_CYC    = T_RST_PWR_US * CLK_MHZ;
    localparam int T_RST_CKE_US   = 500;
    localparam int RST_CKE_CYC    = T_RST_CKE_US * CLK_MHZ;
    localparam int T_CKE_LEAD_NS  = 10;
    localparam int CKE_LEAD_CYC   = max2((T_CKE_LEAD_NS + CLK_NS - 1) / CLK_NS, 1);
    localparam int T_CK_STABLE_NS = 10;
    localparam int CK_STABLE_TCK  = 5;
    localparam int CK_STABLE_CYC  = max2((T_CK_STABLE_NS + CLK_NS - 1) / CLK_NS, CK_STABLE_TCK);
    localparam int T_PW_RESET_NS  = 1000;
    localparam int PW_RESET_CYC   = max2((T_PW_RESET_NS + CLK_NS - 1) / CLK_NS, CKE_LEAD_CYC);
    localparam int T_XS_NS        = 270;
    localparam int XPR_TCK        = 5;
    localparam int TXPR_CYC       = max2((T_XS_NS + CLK_NS - 1) / CLK_NS, XPR_TCK);
    localparam int TMRD_CYC       = 8;
    localparam int TMOD_CYC       = 24;
    localparam int TDLLK_CYC      = 768;
    localparam int TZQINIT_CYC    = 1024;
    localparam int ZQ_WAIT_CYC    = max2(TDLLK_CYC, TZQINIT_CYC);

    // widths
    localparam int CNT_W  = 13;
    localparam int ADDR_W = 18;
    localparam int ROW_W  = 16;
    localparam int DQ_W   = 16;
    localparam int WORD_W = 64;
    localparam int MR_N   = 7;
    localparam int MEM_AW = 9;

    // mode register fields; all-zero reset gives the safe defaults
    localparam logic [17:0] MR_RESET_VAL = 18'h00000;
    localparam logic [1:0]  BL_OTF       = 2'h1;
    localparam logic [1:0]  BL_BC4       = 2'h2;
    localparam int          A_AP         = 10;
    localparam int          A_BC         = 12;
    localparam int          RTT_LSB      = 8;

    // controller register map and fields
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MR0    = 8'h10;
    localparam logic [7:0] REG_ACC_AD = 8'h30;
    localparam logic [7:0] REG_ACC_CM = 8'h34;
    localparam logic [7:0] REG_WD_LO  = 8'h38;
    localparam logic [7:0] REG_WD_HI  = 8'h3C;
    localparam logic [7:0] REG_RD_LO  = 8'h40;
    localparam logic [7:0] REG_RD_HI  = 8'h44;
    localparam int CTRL_ODT   = 0;
    localparam int CTRL_RESET = 1;

    typedef enum logic [2:0] {
        CMD_DES  = 3'h0,
        CMD_MRS  = 3'h1,
        CMD_ZQCL = 3'h2,
        CMD_ACT  = 3'h3,
        CMD_RD   = 3'h4,
        CMD_WR   = 3'h5,
        CMD_PRE  = 3'h6
    } cmd_e;

    // clocks per burst: two for a chopped burst, four for eight beats
    function automatic logic [2:0] burst_clks(input logic [17:0] mr0, input logic a12);
        if (mr0[1:0] == BL_BC4 || (mr0[1:0] == BL_OTF && !a12)) return 3'h2;
        return 3'h4;
    endfunction

    // load order of the mode registers
    function automatic logic [2:0] mr_order(input logic [2:0] i);
        case (i)
            3'h0:    return 3'h3;
            3'h1:    return 3'h6;
            3'h2:    return 3'h5;
            3'h3:    return 3'h4;
            3'h4:    return 3'h2;
            3'h5:    return 3'h1;
            default: return 3'h0;
        endcase
    endfunction
endpackage

// ===== common/ddr_init_if.sv
// link between the memory controller and the DDR4 device
`timescale 1ns/100ps
`default_nettype none
interface ddr_init_if;
    import ddr_init_pkg::*;
    logic              reset_n;
    logic              ten;
    logic              cke;
    logic              ck_run;
    logic              odt;
    cmd_e              cmd;
    logic [1:0]        bg;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   ctrl_dq;
    logic              ctrl_dq_oe;
    logic [DQ_W-1:0]   dev_dq;
    logic              dev_dq_oe;
    logic              dev_rtt_hiz;
    logic [DQ_W-1:0]   dq;

    // shared data wire level
    assign dq = ctrl_dq_oe ? ctrl_dq : (dev_dq_oe ? dev_dq : '0);

    modport ctrl (output reset_n, ten, cke, ck_run, odt, cmd, bg, ba, addr, ctrl_dq, ctrl_dq_oe,
                  input dq, dev_dq_oe, dev_rtt_hiz);
    modport dev (input reset_n, ten, cke, ck_run, odt, cmd, bg, ba, addr, dq,
                 output dev_dq, dev_dq_oe, dev_rtt_hiz);
endinterface
`default_nettype wire

// ===== logic/ddr_init_dev.sv
// DDR4 device end: reset defaults, termination state, mode registers, bursts
`timescale 1ns/100ps
`default_nettype none
module ddr_init_dev (
    input  wire logic       SYS_CLK,
    input  wire logic       RESETN,
    ddr_init_if.dev         LINK,
    input  wire logic [2:0] MR_SEL,
    output logic [17:0]     MR_VALUE,
    output logic            READY
);
    import ddr_init_pkg::*;

    typedef enum logic [1:0] {DS_RESET = 2'h0, DS_INIT = 2'h1, DS_ACTIVE = 2'h2} dstate_e;

    dstate_e           state_q;
    logic [17:0]       mr_q [MR_N];
    logic [ROW_W-1:0]  row_q [16];
    logic [WORD_W-1:0] mem_q [2**MEM_AW];
    logic [MEM_AW-1:0] idx_q;
    logic [2:0]        left_q;
    logic [1:0]        k_q;
    logic              rd_q;
    logic              wr_q;
    logic [DQ_W-1:0]   dq_q;
    logic              oe_q;
    logic [3:0]        bank;
    logic              pin_rst;
    logic              go;

    assign pin_rst = !LINK.reset_n;
    assign bank    = {LINK.bg, LINK.ba};
    assign go      = state_q == DS_ACTIVE && (LINK.cmd == CMD_RD || LINK.cmd == CMD_WR);

    // reset, internal init, then active once CKE is registered high
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= DS_RESET;
        end else if (pin_rst) begin
            state_q <= DS_RESET;
        end else begin
            unique case (state_q)
                DS_RESET:  state_q <= DS_INIT;
                DS_INIT:   if (LINK.cke) state_q <= DS_ACTIVE;
                DS_ACTIVE: state_q <= DS_ACTIVE;
            endcase
        end
    end

    // termination stays high impedance until CKE is seen high
    assign LINK.dev_rtt_hiz = state_q != DS_ACTIVE;

    // mode registers return to defaults on every reset
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < MR_N; i++) mr_q[i] <= MR_RESET_VAL;
        end else if (pin_rst) begin
            for (int i = 0; i < MR_N; i++) mr_q[i] <= MR_RESET_VAL;
        end else if (state_q == DS_ACTIVE && LINK.cmd == CMD_MRS && {LINK.bg[0], LINK.ba} != 3'h7) begin
            mr_q[{LINK.bg[0], LINK.ba}] <= LINK.addr;
        end
    end

    // activate captures the row of the addressed bank
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < 16; i++) row_q[i] <= '0;
        end else if (state_q == DS_ACTIVE && LINK.cmd == CMD_ACT) begin
            row_q[bank] <= LINK.addr[ROW_W-1:0];
        end
    end

    // burst sequencing: column from the read or write command
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            idx_q  <= '0;
            left_q <= '0;
            k_q    <= '0;
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
        end else if (go) begin
            idx_q  <= {bank, row_q[bank][1:0], LINK.addr[5:3]};
            left_q <= burst_clks(mr_q[0], LINK.addr[A_BC]);
            k_q    <= '0;
            rd_q   <= LINK.cmd == CMD_RD;
            wr_q   <= LINK.cmd == CMD_WR;
        end else if (left_q != 3'h0) begin
            left_q <= left_q - 3'h1;
            k_q    <= k_q + 2'h1;
        end else begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end
    end

    // one 64-bit word per burst, two beats per clock
    always_ff @(posedge SYS_CLK) begin
        if (wr_q && left_q != 3'h0) begin
            mem_q[idx_q][{k_q, 4'h0} +: DQ_W] <= LINK.dq;
        end
    end

    // read beats leave from flip-flops
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dq_q <= '0;
            oe_q <= 1'b0;
        end else if (go && LINK.cmd == CMD_RD) begin
            dq_q <= mem_q[{bank, row_q[bank][1:0], LINK.addr[5:3]}][DQ_W-1:0];
            oe_q <= 1'b1;
        end else if (rd_q && left_q > 3'h1) begin
            dq_q <= mem_q[idx_q][{k_q + 2'h1, 4'h0} +: DQ_W];
            oe_q <= 1'b1;
        end else begin
            oe_q <= 1'b0;
        end
    end

    assign LINK.dev_dq    = dq_q;
    assign LINK.dev_dq_oe = oe_q;

    // user-side view of the mode registers and readiness
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            MR_VALUE <= '0;
            READY    <= 1'b0;
        end else begin
            MR_VALUE <= (MR_SEL == 3'h7) ? 18'h00000 : mr_q[MR_SEL];
            READY    <= state_q == DS_ACTIVE;
        end
    end
endmodule
`default_nettype wire

// ===== logic/ddr_init_ctrl.sv
// memory controller end: power-up and reset sequence, mode loads, bursts
`timescale 1ns/100ps
`default_nettype none
module ddr_init_ctrl #(
    parameter int CKE_WAIT_CYC = ddr_init_pkg::max2(ddr_init_pkg::RST_CKE_CYC, ddr_init_pkg::CK_STABLE_CYC)
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    ddr_init_if.ctrl         LINK
);
    import ddr_init_pkg::*;

    typedef enum logic [3:0] {
        CS_HOLD  = 4'h0,
        CS_WAIT  = 4'h1,
        CS_XPR   = 4'h2,
        CS_MRS   = 4'h3,
        CS_MRD   = 4'h4,
        CS_ZQ    = 4'h5,
        CS_ZQW   = 4'h6,
        CS_READY = 4'h7,
        CS_BURST = 4'h8
    } cstate_e;

    cstate_e           state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  hold_q;
    logic [CNT_W-1:0]  wait_q;
    logic [2:0]        seq_q;
    logic [2:0]        nclk_q;
    logic              wr_q;
    logic              rst_n_q;
    logic              cke_q;
    logic              ck_q;
    logic              odt_q;
    cmd_e              cmd_q;
    logic [1:0]        bg_q;
    logic [1:0]        ba_q;
    logic [ADDR_W-1:0] addr_q;
    logic [17:0]       mrv_q [MR_N];
    logic              odt_req_q;
    logic [21:0]       acc_q;
    logic [WORD_W-1:0] wd_q;
    logic [WORD_W-1:0] rd_q;
    logic [1:0]        rk_q;
    logic [DQ_W-1:0]   dq_q;
    logic              oe_q;
    logic [2:0]        sel;
    logic              warm;
    logic              acc_go;
    cmd_e              acc_cmd;

    // mode register slot behind a register address, MR0 at the base
    function automatic logic [2:0] mr_idx(input logic [7:0] a);
        return 3'((a - REG_MR0) >> 2);
    endfunction

    assign sel    = mr_order(seq_q);
    assign warm   = WR && ADDR == REG_CTRL && WDATA[CTRL_RESET];
    assign acc_go = WR && ADDR == REG_ACC_CM && state_q == CS_READY;

    // access code 0 activate, 1 read, 2 write, 3 precharge
    always_comb begin
        unique case (WDATA[1:0])
            2'h0: acc_cmd = CMD_ACT;
            2'h1: acc_cmd = CMD_RD;
            2'h2: acc_cmd = CMD_WR;
            2'h3: acc_cmd = CMD_PRE;
        endcase
    end

    // initialization sequencer and command slots
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= CS_HOLD;
            cnt_q   <= '0;
            hold_q  <= CNT_W'(RST_PWR_CYC);
            wait_q  <= '0;
            seq_q   <= '0;
            nclk_q  <= '0;
            wr_q    <= 1'b0;
            rst_n_q <= 1'b0;
            cke_q   <= 1'b0;
            ck_q    <= 1'b0;
            odt_q   <= 1'b0;
            cmd_q   <= CMD_DES;
            bg_q    <= '0;
            ba_q    <= '0;
            addr_q  <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
            cmd_q <= CMD_DES;
            if (warm) begin
                state_q <= CS_HOLD;
                cnt_q   <= '0;
                hold_q  <= CNT_W'(PW_RESET_CYC);
                rst_n_q <= 1'b0;
                cke_q   <= 1'b0;
                ck_q    <= 1'b0;
            end else begin
                unique case (state_q)
                    CS_HOLD: if (cnt_q == hold_q - CNT_W'(1)) begin
                        rst_n_q <= 1'b1;
                        ck_q    <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= CS_WAIT;
                    end
                    CS_WAIT: if (cnt_q == CNT_W'(CKE_WAIT_CYC - 1)) begin
                        cke_q   <= 1'b1;
                        odt_q   <= odt_req_q && mrv_q[1][RTT_LSB +: 3] == 3'h0;
                        cnt_q   <= '0;
                        state_q <= CS_XPR;
                    end
                    CS_XPR: if (cnt_q == CNT_W'(TXPR_CYC - 1)) begin
                        seq_q   <= '0;
                        state_q <= CS_MRS;
                    end
                    CS_MRS: begin
                        cmd_q   <= CMD_MRS;
                        bg_q    <= {1'b0, sel[2]};
                        ba_q    <= sel[1:0];
                        addr_q  <= mrv_q[sel];
                        wait_q  <= (sel == 3'h0) ? CNT_W'(TMOD_CYC) : CNT_W'(TMRD_CYC);
                        seq_q   <= seq_q + 3'h1;
                        cnt_q   <= '0;
                        state_q <= CS_MRD;
                    end
                    CS_MRD: if (cnt_q == wait_q - CNT_W'(1)) begin
                        state_q <= (seq_q == 3'h7) ? CS_ZQ : CS_MRS;
                    end
                    CS_ZQ: begin
                        cmd_q   <= CMD_ZQCL;
                        cnt_q   <= '0;
                        state_q <= CS_ZQW;
                    end
                    CS_ZQW: if (cnt_q == CNT_W'(ZQ_WAIT_CYC - 1)) begin
                        state_q <= CS_READY;
                    end
                    CS_READY: if (acc_go) begin
                        cmd_q  <= acc_cmd;
                        bg_q   <= acc_q[21:20];
                        ba_q   <= acc_q[19:18];
                        addr_q <= acc_q[17:0];
                        cnt_q  <= '0;
                        if (acc_cmd == CMD_RD || acc_cmd == CMD_WR) begin
                            nclk_q  <= burst_clks(mrv_q[0], acc_q[A_BC]);
                            wr_q    <= acc_cmd == CMD_WR;
                            state_q <= CS_BURST;
                        end
                    end
                    CS_BURST: if (cnt_q == CNT_W'(nclk_q)) begin
                        state_q <= CS_READY;
                    end
                    default: state_q <= CS_HOLD;
                endcase
            end
        end
    end

    assign LINK.reset_n = rst_n_q;
    assign LINK.ten     = 1'b0;
    assign LINK.cke     = cke_q;
    assign LINK.ck_run  = ck_q;
    assign LINK.odt     = odt_q;
    assign LINK.cmd     = cmd_q;
    assign LINK.bg      = bg_q;
    assign LINK.ba      = ba_q;
    assign LINK.addr    = addr_q;

    // write beats, two per clock, for the burst length
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dq_q <= '0;
            oe_q <= 1'b0;
        end else if (state_q == CS_BURST && wr_q && cnt_q < CNT_W'(nclk_q)) begin
            dq_q <= wd_q[{cnt_q[1:0], 4'h0} +: DQ_W];
            oe_q <= 1'b1;
        end else begin
            oe_q <= 1'b0;
        end
    end

    assign LINK.ctrl_dq    = dq_q;
    assign LINK.ctrl_dq_oe = oe_q;

    // read beats gathered while the device drives
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_q <= '0;
            rk_q <= '0;
        end else if (acc_go) begin
            rk_q <= '0;
        end else if (LINK.dev_dq_oe) begin
            rd_q[{rk_q, 4'h0} +: DQ_W] <= LINK.dq;
            rk_q <= rk_q + 2'h1;
        end
    end

    // software-written settings
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < MR_N; i++) mrv_q[i] <= MR_RESET_VAL;
            odt_req_q <= 1'b0;
            acc_q     <= '0;
            wd_q      <= '0;
        end else if (WR) begin
            if (ADDR == REG_CTRL) odt_req_q <= WDATA[CTRL_ODT];
            if (ADDR >= REG_MR0 && ADDR < REG_MR0 + 8'h1C && ADDR[1:0] == 2'h0)
                mrv_q[mr_idx(ADDR)] <= WDATA[17:0];
            if (ADDR == REG_ACC_AD) acc_q <= WDATA[21:0];
            if (ADDR == REG_WD_LO) wd_q[31:0] <= WDATA;
            if (ADDR == REG_WD_HI) wd_q[63:32] <= WDATA;
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= '0;
        end else if (RD) begin
            if (ADDR >= REG_MR0 && ADDR < REG_MR0 + 8'h1C && ADDR[1:0] == 2'h0)
                RDATA <= {14'h0000, mrv_q[mr_idx(ADDR)]};
            else if (ADDR == REG_CTRL) RDATA <= {31'h00000000, odt_req_q};
            else if (ADDR == REG_STATUS)
                RDATA <= {25'h0000000, cke_q, state_q == CS_READY, LINK.dev_rtt_hiz, state_q};
            else if (ADDR == REG_ACC_AD) RDATA <= {10'h000, acc_q};
            else if (ADDR == REG_WD_LO) RDATA <= wd_q[31:0];
            else if (ADDR == REG_WD_HI) RDATA <= wd_q[63:32];
            else if (ADDR == REG_RD_LO) RDATA <= rd_q[31:0];
            else if (ADDR == REG_RD_HI) RDATA <= rd_q[63:32];
            else RDATA <= '0;
        end
    end
endmodule
`default_nettype wire

// ===== bench/ddr_init_props.sv
// link checker: reset, clock enable, termination and command timing
`timescale 1ns/100ps
`default_nettype none
module ddr_init_props #(
    parameter int CKE_WAIT_CYC = 20
) (
    input wire logic                SYS_CLK,
    input wire logic                RESETN,
    input wire logic                reset_n,
    input wire logic                ten,
    input wire logic                cke,
    input wire logic                ck_run,
    input wire logic                odt,
    input wire ddr_init_pkg::cmd_e  cmd,
    input wire logic [1:0]          bg,
    input wire logic [1:0]          ba,
    input wire logic                ctrl_dq_oe,
    input wire logic                dev_dq_oe,
    input wire logic                dev_rtt_hiz
);
    import ddr_init_pkg::*;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    logic [15:0] zq_q;
    logic        pwr_q;

    // cycles with link reset low, cycles since its release, power-up done flag
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lo_q  <= 16'h0000;
            hi_q  <= 16'h0000;
            pwr_q <= 1'b0;
        end else begin
            lo_q  <= reset_n ? 16'h0000 : lo_q + 16'h0001;
            hi_q  <= reset_n ? hi_q + 16'h0001 : 16'h0000;
            pwr_q <= pwr_q | reset_n;
        end
    end

    // cycles since the last calibration start, zero until one is issued after link reset
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            zq_q <= 16'h0000;
        end else if (!reset_n) begin
            zq_q <= 16'h0000;
        end else if (cmd == CMD_ZQCL) begin
            zq_q <= 16'h0001;
        end else if (zq_q != 16'h0000) begin
            zq_q <= zq_q + 16'h0001;
        end
    end

    ten_low_a: assert property (ten == 1'b0) else $error("test enable high");
    rst_hold_a: assert property ($rose(reset_n) |-> lo_q >= (pwr_q ? PW_RESET_CYC - 1 : RST_PWR_CYC - 1))
        else $error("link reset released too early");
    cke_lead_a: assert property ($rose(reset_n) |-> !cke && $past(!cke)) else $error("cke high at release");
    cke_wait_a: assert property ($rose(cke) |-> hi_q >= CKE_WAIT_CYC - 1) else $error("cke raised too early");
    clk_stable_a: assert property ($rose(cke) |-> $past(ck_run, 5)) else $error("clock not stable at cke");
    des_first_a: assert property ($rose(cke) |-> cmd == CMD_DES) else $error("no deselect at cke rise");
    cke_hold_a: assert property ($fell(cke) |-> ##[0:2] !reset_n) else $error("cke dropped in init");
    rtt_off_a: assert property (!reset_n && $past(!reset_n) |-> dev_rtt_hiz) else $error("termination on");
    rtt_on_a: assert property ($rose(cke) |-> dev_rtt_hiz ##1 !dev_rtt_hiz) else $error("termination late");
    odt_static_a: assert property (cke && $past(cke) |-> $stable(odt)) else $error("odt moved");
    xpr_wait_a: assert property ($rose(cke) |-> (cmd != CMD_MRS) [*5]) else $error("mode load before xpr");
    mrd_gap_a: assert property (cmd == CMD_MRS |=> (cmd == CMD_DES) [*7]) else $error("mrd gap short");
    mrs_sel_a: assert property (cmd == CMD_MRS |-> !bg[1] && {bg[0], ba} != 3'h7) else $error("bad select");
    idle_des_a: assert property (!cke |-> cmd == CMD_DES) else $error("command while cke low");
    access_late_a: assert property (cmd inside {CMD_ACT, CMD_RD, CMD_WR} |-> zq_q > ZQ_WAIT_CYC)
        else $error("access before calibration end");
    wr_beats_a: assert property (cmd == CMD_WR |=> ctrl_dq_oe [*2]) else $error("write beats missing");
    rd_beats_a: assert property (cmd == CMD_RD |=> dev_dq_oe [*2]) else $error("read beats missing");
    cke_c: cover property ($rose(cke));
    zq_c: cover property (cmd == CMD_ZQCL);
    wr_c: cover property (cmd == CMD_WR);
    rd_c: cover property (cmd == CMD_RD);
endmodule
`default_nettype wire

// ===== bench/sdram_power_up_reset_init_tb_top.sv
// bench: controller and device joined, driven over the register port
`timescale 1ns/100ps
`default_nettype none
module sdram_power_up_reset_init_tb_top;
    import ddr_init_pkg::*;
    localparam int CKE_WAIT = RST_CKE_CYC;
    logic        sys_clk;
    logic        resetn;
    logic        wr;
    logic        rd;
    logic        rd_p;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [2:0]  mr_sel;
    logic [17:0] mr_value;
    logic        ready;
    logic [15:0] seed;
    logic [31:0] w;
    logic [31:0] w0hi;
    logic [31:0] ra;
    logic [31:0] ca;
    int          n_fail;
    int          checks;
    logic [31:0] exp_q[$];
    logic [2:0]  mrs_sel[$];
    logic [17:0] mrs_adr[$];
    logic [17:0] mrv[8];
    logic [2:0]  ord[7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};

    ddr_init_if link();
    ddr_init_ctrl #(.CKE_WAIT_CYC(CKE_WAIT)) ddr_init_ctrl_i (.SYS_CLK(sys_clk), .RESETN(resetn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINK(link));
    ddr_init_dev ddr_init_dev_i (.SYS_CLK(sys_clk), .RESETN(resetn), .LINK(link), .MR_SEL(mr_sel),
        .MR_VALUE(mr_value), .READY(ready));
    ddr_init_props #(.CKE_WAIT_CYC(CKE_WAIT)) ddr_init_props_i (.SYS_CLK(sys_clk), .RESETN(resetn),
        .reset_n(link.reset_n), .ten(link.ten), .cke(link.cke), .ck_run(link.ck_run), .odt(link.odt),
        .cmd(link.cmd), .bg(link.bg), .ba(link.ba), .ctrl_dq_oe(link.ctrl_dq_oe), .dev_dq_oe(link.dev_dq_oe),
        .dev_rtt_hiz(link.dev_rtt_hiz));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] nxt();
        logic [31:0] v;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        v[15:0] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        v[31:16] = seed;
        return v;
    endfunction

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        rd   <= 1'b0;
    endtask

    task automatic acc(input logic [31:0] a, input logic [31:0] c);
        wr_reg(REG_ACC_AD, a);
        wr_reg(REG_ACC_CM, c);
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic chk_mr();
        for (int i = 0; i < 8; i++) begin
            mr_sel <= 3'(i);
            repeat (2) @(posedge sys_clk);
            chk(mr_value, mrv[i]);
        end
    endtask

    // wait for calibration start, then its fixed wait
    task automatic wait_init();
        int n;
        n = 0;
        while (link.cmd !== CMD_ZQCL && n < 9000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 9000) n_fail++;
        repeat (ZQ_WAIT_CYC + 4) @(posedge sys_clk);
    endtask

    task automatic post_init(input logic odt_e);
        chk(link.odt, odt_e);
        chk(ready, 1'b1);
        rd_reg(REG_STATUS, 32'h00000067);
        for (int k = 0; k < 7; k++) begin
            chk(mrs_sel[k], ord[k]);
            chk(mrs_adr[k], mrv[ord[k]]);
        end
        mrs_sel.delete();
        mrs_adr.delete();
        chk_mr();
    endtask

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // read results and mode loads seen on the link
    always @(posedge sys_clk) begin
        rd_p <= rd;
        if (link.cmd == CMD_MRS) begin
            mrs_sel.push_back({link.bg[0], link.ba});
            mrs_adr.push_back(link.addr);
        end
    end
    always @(negedge sys_clk) begin
        if (rd_p) chk(rdata, exp_q.pop_front());
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end

    // main sequence
    initial begin
        {resetn, wr, rd, addr, wdata, mr_sel} = '0;
        seed = 16'h000E;
        n_fail = 0;
        checks = 0;
        foreach (mrv[i]) mrv[i] = 18'h00000;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        chk_mr();
        for (int i = 0; i < 7; i++) begin
            w = nxt();
            mrv[i] = (i == 0) ? {16'h0000, BL_OTF} : (i == 1) ? (w[17:0] & 18'h3F8FF) : w[17:0];
            wr_reg(REG_MR0 + 8'(4 * i), {14'h0000, mrv[i]});
        end
        wr_reg(REG_CTRL, 32'h00000001);
        wr_reg(8'hF0, 32'hFFFFFFFF);
        rd_reg(8'hF0, 32'h00000000);
        rd_reg(REG_MR0 + 8'h04, {14'h0000, mrv[1]});
        // a read asked for during initialization must be ignored
        acc(32'h00000000, 32'h00000001);
        chk(link.reset_n, 1'b0);
        wait_init();
        post_init(1'b1);
        w = nxt();
        ra = {10'h000, w[21:0]};
        ca = {ra[31:18], 18'h01028};
        acc(ra, 32'h0);
        w = nxt();
        wr_reg(REG_WD_LO, w);
        w0hi = nxt();
        wr_reg(REG_WD_HI, w0hi);
        acc(ca, 32'h2);
        w = nxt();
        wr_reg(REG_WD_LO, w);
        acc(ca & ~32'h00001000, 32'h2);
        acc(ra ^ 32'h00100000, 32'h0);
        wr_reg(REG_WD_LO, ~w);
        acc(ca ^ 32'h00100000, 32'h2);
        acc(ca, 32'h1);
        rd_reg(REG_RD_LO, w);
        rd_reg(REG_RD_HI, w0hi);
        // nominal termination on in MR1: odt must come up low after warm reset
        mrv[1] = mrv[1] | 18'h00100;
        wr_reg(REG_MR0 + 8'h04, {14'h0000, mrv[1]});
        wr_reg(REG_CTRL, 32'h00000003);
        mr_sel <= 3'h1;
        repeat (3) @(posedge sys_clk);
        chk(mr_value, 18'h00000);
        chk(link.cke, 1'b0);
        wait_init();
        post_init(1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
